// [hw/boot_pkg.sv]
// Package: constants of the power-on boot sequencer
// Assumes a 10 MHz system clock and a byte-wide serial memory behind SPI
package boot_pkg;
  localparam int unsigned CLK_HZ         = 10000000;
  localparam int unsigned START_DELAY_MS = 200;
  localparam int unsigned RETRY_MS       = 1000;
  localparam int unsigned START_CYCLES   = CLK_HZ / 1000 * START_DELAY_MS;
  localparam int unsigned RETRY_CYCLES   = CLK_HZ / 1000 * RETRY_MS;
  localparam int unsigned SCK_HALF       = 2;
  localparam logic [7:0]  CMD_READ       = 8'h03;
  localparam logic [7:0]  MAGIC          = 8'hA5;
  localparam logic [15:0] IMG_BASE       = 16'h0000;
  localparam logic [15:0] PC_RESET       = 16'h0000;
  localparam int unsigned HDR_BYTES      = 3;
  localparam int unsigned MAX_WORDS      = 1024;
  localparam int unsigned FIFO_DEPTH     = 4;
  localparam int unsigned FIFO_WIDTH     = 8;
  localparam logic [23:0] RD_ADDR        = 24'h000000;
endpackage

// [hw/byte_fifo.sv]
// Small synchronous FIFO between the serial reader and the image checker
// Assumes one clock and a synchronous active-low reset
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW:0]      cnt_r, cnt_nxt;
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic             push, pop;

  // Handshakes and pointer update
  always_comb
  begin
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    mem_nxt = mem_r;
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    if (push)
    begin
      mem_nxt[wp_r] = in_data;
      wp_nxt        = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
    if (pop)
      rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
    cnt_nxt = cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  assign in_ready  = (cnt_r != (AW + 1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];

  // State registers
  always_ff @(posedge clk)
  begin
    mem_r <= mem_nxt;
    if (!rst_n)
    begin
      cnt_r <= '0;
      wp_r  <= '0;
      rp_r  <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
    end
  end
endmodule // byte_fifo

// [hw/por_boot_loader.sv]
// Power-on boot sequencer: waits, reads the boot image over SPI, checks it,
// writes program RAM and releases the DSP core at the image start.
// Assumes RST_N is the power-on reset, synchronous to CLK; SPI_MISO is async.
//
// Behaviour
// - Power-on reset puts every control and core register here into a known default.
// - Audio outputs stay muted throughout the whole power-on procedure.
// - Reading the first-stage image starts 200 ms after reset release.
// - The image is checked for validity, which also checks its file structure.
// - Program RAM is written only once the structure has passed the check; here words are written after the header check, before the checksum test.
// - On a read error outputs stay muted and boot is retried about once per second.
// - After loading, the core program counter is set to the first image address.
// - The running bootloader then copies the application; this block just releases the core.
`timescale 1ns/10ps
module por_boot_loader #(
  parameter int unsigned START_CYC = boot_pkg::START_CYCLES,
  parameter int unsigned RETRY_CYC = boot_pkg::RETRY_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  output logic             SPI_SCK,
  output logic             SPI_CS_N,
  output logic             SPI_MOSI,
  input  wire logic        SPI_MISO,
  output logic             PROGRAM_RAM_WE,
  output logic [15:0]      PROGRAM_RAM_ADDR,
  output logic [15:0]      PROGRAM_RAM_WDATA,
  output logic             CORE_RUN,
  output logic [15:0]      CORE_PC,
  output logic             AUDIO_MUTE,
  output logic             BOOT_ERROR
);
  typedef enum logic [2:0] {
    S_WAIT = 3'b000, S_CMD = 3'b001, S_HDR = 3'b011, S_BODY = 3'b010,
    S_CHK  = 3'b110, S_RUN = 3'b111, S_ERR = 3'b100
  } state_t;

  // ------------------------------------------------------------
  // Input synchroniser
  // ------------------------------------------------------------
  logic miso_s1_r, miso_s2_r;
  always_ff @(posedge CLK)
  begin
    miso_s1_r <= SPI_MISO;
    miso_s2_r <= miso_s1_r;
  end

  // ------------------------------------------------------------
  // Sequencer and SPI shifter
  // ------------------------------------------------------------
  state_t      st_r, st_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [1:0]  div_r, div_nxt;
  logic        sck_r, sck_nxt, cs_n_r, cs_n_nxt, mosi_r, mosi_nxt;
  logic [31:0] sh_out_r, sh_out_nxt;
  logic [7:0]  sh_in_r, sh_in_nxt;
  logic [5:0]  bit_r, bit_nxt;
  logic        rx_valid_r, rx_valid_nxt;
  logic        rd_busy_r, rd_busy_nxt;
  logic [15:0] total_r, total_nxt;
  logic [15:0] rcvd_r, rcvd_nxt;
  logic        fifo_in_ready, fifo_out_valid;
  logic [7:0]  fifo_out_data;
  logic        chk_ready;
  logic [15:0] addr_r, addr_nxt, pc_r, pc_nxt;

  // Byte stream buffered before the checker
  byte_fifo #(.WIDTH(boot_pkg::FIFO_WIDTH), .DEPTH(boot_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .rst_n     (RST_N),
    .in_data   (sh_in_r),
    .in_valid  (rx_valid_r),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (chk_ready)
  );

  // ------------------------------------------------------------
  // Image checker and program RAM writer
  // ------------------------------------------------------------
  logic [1:0]  hidx_r, hidx_nxt;
  logic [15:0] len_r, len_nxt;
  logic [7:0]  sum_r, sum_nxt;
  logic        lo_r, lo_nxt;
  logic [7:0]  lob_r, lob_nxt;
  logic [15:0] waddr_r, waddr_nxt;
  logic        we_r, we_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic        run_r, run_nxt, err_r, err_nxt, mute_r;

  // The error state drains the FIFO so a retry never sees stale bytes
  assign chk_ready = (st_r == S_HDR) || (st_r == S_BODY) || (st_r == S_ERR);

  // Next-state logic of the whole sequencer
  always_comb
  begin
    st_nxt       = st_r;
    tmr_nxt      = tmr_r;
    div_nxt      = div_r;
    sck_nxt      = sck_r;
    cs_n_nxt     = cs_n_r;
    mosi_nxt     = mosi_r;
    sh_out_nxt   = sh_out_r;
    sh_in_nxt    = sh_in_r;
    bit_nxt      = bit_r;
    rx_valid_nxt = 1'b0;
    rd_busy_nxt  = rd_busy_r;
    total_nxt    = total_r;
    rcvd_nxt     = rcvd_r;
    hidx_nxt     = hidx_r;
    len_nxt      = len_r;
    sum_nxt      = sum_r;
    lo_nxt       = lo_r;
    lob_nxt      = lob_r;
    waddr_nxt    = waddr_r;
    we_nxt       = 1'b0;
    wdata_nxt    = wdata_r;
    run_nxt      = run_r;
    err_nxt      = err_r;
    addr_nxt     = addr_r;
    pc_nxt       = pc_r;

    // SPI clocking: runs while reading, paused when the FIFO is full
    if (rd_busy_r && !(fifo_in_ready == 1'b0 && bit_r == 6'd32 && !sck_r))
    begin
      div_nxt = div_r + 2'd1;
      if (div_r == 2'(boot_pkg::SCK_HALF - 1))
      begin
        div_nxt = '0;
        sck_nxt = !sck_r;
        if (sck_r)
        begin
          // Sample at the fall: the two-flop delay hides the bit until then
          sh_in_nxt  = {sh_in_r[6:0], miso_s2_r};
          bit_nxt    = bit_r + 6'd1;
          sh_out_nxt = {sh_out_r[30:0], 1'b0};
          mosi_nxt   = sh_out_r[30];
          if (bit_r >= 6'd39 && bit_r[2:0] == 3'd7)
          begin
            rx_valid_nxt = 1'b1;
            rcvd_nxt     = rcvd_r + 16'd1;
            bit_nxt      = 6'd32;
            // Length is unknown until the header is parsed, so keep reading
            if (rcvd_r + 16'd1 == total_r && st_r != S_HDR && st_r != S_CMD)
            begin
              rd_busy_nxt = 1'b0;
              cs_n_nxt    = 1'b1;
            end
          end
        end
      end
    end

    case (st_r)
      S_WAIT:
      begin
        tmr_nxt = tmr_r + 32'd1;
        if (tmr_r >= START_CYC - 1)
        begin
          tmr_nxt     = '0;
          st_nxt      = S_CMD;
          cs_n_nxt    = 1'b0;
          sh_out_nxt  = {boot_pkg::CMD_READ, boot_pkg::RD_ADDR};
          mosi_nxt    = boot_pkg::CMD_READ[7];
          bit_nxt     = '0;
          div_nxt     = '0;
          rd_busy_nxt = 1'b1;
          rcvd_nxt    = '0;
          total_nxt   = 16'(boot_pkg::HDR_BYTES);
          hidx_nxt    = '0;
          sum_nxt     = '0;
          lo_nxt      = 1'b1;
          waddr_nxt   = boot_pkg::IMG_BASE;
        end
      end
      S_CMD:
        st_nxt = S_HDR;
      S_HDR:
        if (fifo_out_valid)
        begin
          hidx_nxt = hidx_r + 2'd1;
          if (hidx_r == 2'd0 && fifo_out_data != boot_pkg::MAGIC)
            st_nxt = S_ERR;
          else if (hidx_r == 2'd1)
            len_nxt[7:0] = fifo_out_data;
          else if (hidx_r == 2'd2)
          begin
            len_nxt = {fifo_out_data, len_r[7:0]};
            if (fifo_out_data == 8'h00 && len_r[7:0] == 8'h00 ||
                {fifo_out_data, len_r[7:0]} > 16'(boot_pkg::MAX_WORDS))
              st_nxt = S_ERR;
            else
            begin
              st_nxt    = S_BODY;
              total_nxt = 16'(boot_pkg::HDR_BYTES) + {fifo_out_data, len_r[6:0], 1'b0} + 16'd1;
            end
          end
        end
      S_BODY:
        if (fifo_out_valid)
        begin
          sum_nxt = sum_r + fifo_out_data;
          if (waddr_r == len_r)
            st_nxt = S_CHK;
          else if (lo_r)
          begin
            lob_nxt = fifo_out_data;
            lo_nxt  = 1'b0;
          end
          else
          begin
            lo_nxt = 1'b1;
            we_nxt = 1'b1;
            wdata_nxt = {fifo_out_data, lob_r};
            waddr_nxt = waddr_r + 16'd1;
            addr_nxt  = waddr_r;
          end
        end
      S_CHK:
        if (sum_r == 8'h00)
        begin
          st_nxt  = S_RUN;
          run_nxt = 1'b1;
          pc_nxt  = boot_pkg::PC_RESET;
        end
        else
          st_nxt = S_ERR;
      S_RUN:
        run_nxt = 1'b1;
      S_ERR:
      begin
        tmr_nxt = tmr_r + 32'd1;
        // Abort only in a low clock phase so no short clock pulse escapes
        if (!sck_r)
        begin
          err_nxt     = 1'b1;
          rd_busy_nxt = 1'b0;
          cs_n_nxt    = 1'b1;
          sck_nxt     = 1'b0;
          div_nxt     = '0;
        end
        if (tmr_r >= RETRY_CYC - 1)
        begin
          tmr_nxt = START_CYC - 1;
          st_nxt  = S_WAIT;
        end
      end
      default:
        st_nxt = S_WAIT;
    endcase
  end

  // Registers; all return to defaults on power-on reset
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      st_r       <= S_WAIT;
      tmr_r      <= '0;
      div_r      <= '0;
      sck_r      <= 1'b0;
      cs_n_r     <= 1'b1;
      mosi_r     <= 1'b0;
      sh_out_r   <= '0;
      sh_in_r    <= '0;
      bit_r      <= '0;
      rx_valid_r <= 1'b0;
      rd_busy_r  <= 1'b0;
      total_r    <= '0;
      rcvd_r     <= '0;
      hidx_r     <= '0;
      len_r      <= '0;
      sum_r      <= '0;
      lo_r       <= 1'b1;
      lob_r      <= '0;
      waddr_r    <= '0;
      we_r       <= 1'b0;
      wdata_r    <= '0;
      run_r      <= 1'b0;
      err_r      <= 1'b0;
      mute_r     <= 1'b1;
      addr_r     <= '0;
      pc_r       <= boot_pkg::PC_RESET;
    end
    else
    begin
      st_r       <= st_nxt;
      tmr_r      <= tmr_nxt;
      div_r      <= div_nxt;
      sck_r      <= sck_nxt;
      cs_n_r     <= cs_n_nxt;
      mosi_r     <= mosi_nxt;
      sh_out_r   <= sh_out_nxt;
      sh_in_r    <= sh_in_nxt;
      bit_r      <= bit_nxt;
      rx_valid_r <= rx_valid_nxt;
      rd_busy_r  <= rd_busy_nxt;
      total_r    <= total_nxt;
      rcvd_r     <= rcvd_nxt;
      hidx_r     <= hidx_nxt;
      len_r      <= len_nxt;
      sum_r      <= sum_nxt;
      lo_r       <= lo_nxt;
      lob_r      <= lob_nxt;
      waddr_r    <= waddr_nxt;
      we_r       <= we_nxt;
      wdata_r    <= wdata_nxt;
      run_r      <= run_nxt;
      err_r      <= err_nxt;
      mute_r     <= !run_nxt;
      addr_r     <= addr_nxt;
      pc_r       <= pc_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign SPI_SCK    = sck_r;
  assign SPI_CS_N   = cs_n_r;
  assign SPI_MOSI   = mosi_r;
  assign PROGRAM_RAM_WE    = we_r;
  assign PROGRAM_RAM_ADDR  = addr_r;
  assign PROGRAM_RAM_WDATA = wdata_r;
  assign CORE_RUN   = run_r;
  assign CORE_PC    = pc_r;
  assign AUDIO_MUTE = mute_r;
  assign BOOT_ERROR = err_r;
endmodule // por_boot_loader

// [testbench/por_boot_loader_asserts.sv]
// Checker: port-level assertions of the power-on boot sequencer
// Assumes binding to por_boot_loader with the same count parameters
`timescale 1ns/10ps
module por_boot_loader_asserts #(
  parameter int unsigned START_CYC = 50,
  parameter int unsigned RETRY_CYC = 200
) (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        SPI_SCK,
  input wire logic        SPI_CS_N,
  input wire logic        PROGRAM_RAM_WE,
  input wire logic        CORE_RUN,
  input wire logic [15:0] CORE_PC,
  input wire logic        AUDIO_MUTE,
  input wire logic        BOOT_ERROR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  // Cycles since reset release, saturating at the start delay
  always_comb cnt_nxt = (cnt_r < START_CYC) ? cnt_r + 32'h1 : cnt_r;
  always_ff @(posedge CLK) cnt_r <= RST_N ? cnt_nxt : 32'h0;
  chk_reset_state: assert property (disable iff (1'b0) !RST_N |=> SPI_CS_N && AUDIO_MUTE && !CORE_RUN && !BOOT_ERROR)
    else $error("outputs not in reset state");
  chk_mute_until_run: assert property (!CORE_RUN |-> AUDIO_MUTE)
    else $error("unmuted before core release");
  chk_run_unmute: assert property ($rose(CORE_RUN) |=> !AUDIO_MUTE)
    else $error("mute not lifted after release");
  chk_start_wait: assert property (cnt_r < START_CYC - 1 |-> SPI_CS_N)
    else $error("read started too early");
  chk_write_after_read: assert property (PROGRAM_RAM_WE |-> !SPI_CS_N && !CORE_RUN && AUDIO_MUTE)
    else $error("program write outside the image load");
  chk_we_pulse: assert property (PROGRAM_RAM_WE |=> !PROGRAM_RAM_WE)
    else $error("write strobe longer than one cycle");
  chk_error_quiet: assert property ($rose(BOOT_ERROR) |-> !CORE_RUN ##1 (SPI_CS_N && AUDIO_MUTE)[*8])
    else $error("no quiet muted pause after error");
  chk_start_pc: assert property (CORE_RUN |-> CORE_PC == boot_pkg::PC_RESET)
    else $error("core start address wrong");
  chk_run_held: assert property (CORE_RUN |=> CORE_RUN)
    else $error("core release dropped");
  chk_sck_idle: assert property (SPI_CS_N |-> !SPI_SCK)
    else $error("serial clock moves while deselected");
  chk_sck_half: assert property ($rose(SPI_SCK) |=> SPI_SCK ##1 !SPI_SCK)
    else $error("serial clock half period wrong");
  cov_boot_ok: cover property ($rose(CORE_RUN));
  cov_boot_err: cover property ($rose(BOOT_ERROR));
  cov_retry: cover property ($fell(SPI_CS_N) && BOOT_ERROR);
endmodule // por_boot_loader_asserts

bind por_boot_loader por_boot_loader_asserts #(.START_CYC(START_CYC), .RETRY_CYC(RETRY_CYC)) u_por_boot_loader_asserts (
  .CLK(CLK), .RST_N(RST_N), .SPI_SCK(SPI_SCK), .SPI_CS_N(SPI_CS_N), .PROGRAM_RAM_WE(PROGRAM_RAM_WE),
  .CORE_RUN(CORE_RUN),
  .CORE_PC(CORE_PC), .AUDIO_MUTE(AUDIO_MUTE), .BOOT_ERROR(BOOT_ERROR));

// [testbench/spi_eeprom_model.sv]
// Model of the serial memory that holds the boot image, SPI mode 0
// Assumes the loader sends an 8-bit command and a 24-bit address first
`timescale 1ns/10ps
module spi_eeprom_model (
  input wire logic        sck,
  input wire logic        cs_n,
  input wire logic        mosi,
  input wire logic [1:0]  mode,
  output logic            miso,
  output logic [31:0]     cmd
);
  logic [7:0] img [0:7];
  int         bitn = 0;
  logic       lastb = 1'b1;
  // Two-word image; mode 1 bad magic, 2 bad checksum, 3 zero length
  always_comb
  begin
    img = '{8'hA5, 8'h02, 8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h56};
    if (mode == 2'h1) img[0] = 8'h5A;
    if (mode == 2'h2) img[7] = 8'h57;
    if (mode == 2'h3) img[1] = 8'h00;
  end
  initial miso = 1'b0;
  always @(negedge cs_n) bitn = 0;
  // Command bits in on rising clock; image bytes out in address order
  always @(posedge sck)
  begin
    if (!cs_n && bitn < 32) cmd = {cmd[30:0], mosi};
    if (!cs_n) bitn = bitn + 1;
  end
  always @(negedge sck)
  begin
    if (!cs_n && bitn >= 32) lastb = img[((bitn - 32) / 8) % 8][7 - ((bitn - 32) % 8)];
    if (!cs_n && bitn >= 32) miso = lastb;
  end
  // Released line shows the opposite of the last bit
  always @(posedge cs_n) miso = ~lastb;
endmodule // spi_eeprom_model

// [testbench/por_boot_loader_tb_top.sv]
// Testbench: boots good and broken images through the memory model
// Assumes shortened start and retry counts of 50 and 200 cycles
`timescale 1ns/10ps
module por_boot_loader_tb_top;
  localparam int unsigned START_C = 50;
  localparam int unsigned RETRY_C = 200;
  typedef struct {logic [1:0] mode; logic err; int nw;} row_t;
  logic CLK = 1'b0, RST_N = 1'b0, SPI_SCK, SPI_CS_N, SPI_MOSI, SPI_MISO, PROGRAM_RAM_WE, CORE_RUN, AUDIO_MUTE;
  logic BOOT_ERROR;
  logic [15:0] PROGRAM_RAM_ADDR, PROGRAM_RAM_WDATA, CORE_PC;
  logic [15:0] wa [0:3];
  logic [15:0] wd [0:3];
  logic [31:0] cmd;
  logic [1:0]  mode = 2'h0;
  int          nwr = 0, miscompares = 0, num_checks = 0;
  row_t        rows [0:3] = '{'{2'h0, 1'b0, 2}, '{2'h1, 1'b1, 0}, '{2'h2, 1'b1, 2}, '{2'h3, 1'b1, 0}};
  por_boot_loader #(.START_CYC(START_C), .RETRY_CYC(RETRY_C)) u_por_boot_loader (.CLK(CLK), .RST_N(RST_N),
    .SPI_SCK(SPI_SCK), .SPI_CS_N(SPI_CS_N), .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO),
    .PROGRAM_RAM_WE(PROGRAM_RAM_WE), .PROGRAM_RAM_ADDR(PROGRAM_RAM_ADDR),
    .PROGRAM_RAM_WDATA(PROGRAM_RAM_WDATA), .CORE_RUN(CORE_RUN), .CORE_PC(CORE_PC),
    .AUDIO_MUTE(AUDIO_MUTE), .BOOT_ERROR(BOOT_ERROR));
  spi_eeprom_model u_spi_eeprom_model (.sck(SPI_SCK), .cs_n(SPI_CS_N), .mosi(SPI_MOSI), .mode(mode),
    .miso(SPI_MISO), .cmd(cmd));
  always #50 CLK = ~CLK;
  // Count every program write; keep address and data of the first four only
  always @(posedge CLK)
  begin
    if (PROGRAM_RAM_WE === 1'b1 && nwr < 4) wa[nwr] = PROGRAM_RAM_ADDR;
    if (PROGRAM_RAM_WE === 1'b1 && nwr < 4) wd[nwr] = PROGRAM_RAM_WDATA;
    if (PROGRAM_RAM_WE === 1'b1) nwr = nwr + 1;
  end
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin miscompares++; $display("FAIL t=%0t got=%h exp=%h", $time, got, exp); end
  endtask
  task automatic stop_test;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #10;
  endtask
  // Reset for 12 cycles, check defaults, count cycles to first select
  task automatic boot_reset;
    int k;
    tick(1);
    RST_N = 1'b0;
    nwr = 0;
    tick(12);
    check({SPI_CS_N, SPI_SCK, AUDIO_MUTE, CORE_RUN, PROGRAM_RAM_WE, BOOT_ERROR}, 6'h28);
    RST_N = 1'b1;
    k = 0;
    while (SPI_CS_N !== 1'b0 && k < 500) begin tick(1); k++; end
    check(k >= START_C - 2 && k <= START_C + 3, 1);
  endtask
  // A sticky error flag from an earlier attempt is ignored when run_only is set
  task automatic wait_end(input bit run_only);
    int k;
    k = 0;
    while (CORE_RUN !== 1'b1 && (run_only || BOOT_ERROR !== 1'b1) && k < 3000) begin tick(1); k++; end
    tick(2);
  endtask
  // Time from error to the next select; muted at the select, without writes meanwhile
  task automatic check_retry;
    int k;
    int n0;
    k = 0;
    n0 = nwr;
    while (SPI_CS_N !== 1'b0 && k < 1000) begin tick(1); k++; end
    check(k >= RETRY_C - 40 && k <= RETRY_C + 40, 1);
    check({AUDIO_MUTE, CORE_RUN, 8'(nwr - n0)}, 10'h200);
  endtask
  initial
  begin
    repeat (30000) @(posedge CLK);
    miscompares++;
    stop_test;
  end
  initial
  begin
    for (int i = 0; i < 4; i++)
    begin
      mode = rows[i].mode;
      boot_reset;
      wait_end(1'b0);
      check(cmd, {boot_pkg::CMD_READ, boot_pkg::RD_ADDR});
      check({BOOT_ERROR, AUDIO_MUTE, CORE_RUN}, {rows[i].err, rows[i].err, !rows[i].err});
      check(nwr, rows[i].nw);
      if (!rows[i].err) check({wa[0], wd[0], wa[1], wd[1]}, 64'h0000_2211_0001_4433);
      if (!rows[i].err) check(CORE_PC, boot_pkg::PC_RESET);
      if (rows[i].err) check_retry;
      $display("test %0d done", i);
    end
    // Bad checksum, then the memory is repaired and the retry must boot
    mode = 2'h2;
    boot_reset;
    wait_end(1'b0);
    mode = 2'h0;
    check_retry;
    wait_end(1'b1);
    check({BOOT_ERROR, CORE_RUN, AUDIO_MUTE, 8'(nwr)}, 11'h604);
    $display("test retry done");
    stop_test;
  end
endmodule // por_boot_loader_tb_top
